// file: adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] CTRL_ONE_ADDR    = 8'h0e;
    localparam logic [7:0] CTRL_TWO_ADDR    = 8'h0f;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'h20;
    localparam logic [7:0] RESULT_LOW_ADDR  = 8'h21;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CHAN_LSB      = 0;
    localparam int AIN_OFF_BIT   = 4;
    localparam int MODE_LSB      = 5;
    localparam int START_BIT     = 7;
    localparam int CONV_TIME_LSB = 1;
    localparam int EOC_BIT       = 5;
    localparam int BUSY_BIT      = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [5:0] CTRL_TWO_RESET = 6'h00;
    localparam logic [9:0] RESULT_RESET   = 10'h000;

    // ********************************************************
    // Conversion lengths in high_freq_clock cycles
    // ********************************************************
    localparam logic [10:0] CONV_CYC_39   = 11'h027;
    localparam logic [10:0] CONV_CYC_78   = 11'h04e;
    localparam logic [10:0] CONV_CYC_156  = 11'h09c;
    localparam logic [10:0] CONV_CYC_312  = 11'h138;
    localparam logic [10:0] CONV_CYC_624  = 11'h270;
    localparam logic [10:0] CONV_CYC_1248 = 11'h4e0;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_RSVD   = 2'b10,
        MODE_REPEAT = 2'b11
    } operating_mode_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_e;

endpackage : adc_ctrl_pkg

// file: conv_timer.sv
`timescale 1ns/1ns
module conv_timer
    import adc_ctrl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [10:0] cycles,
    output logic             done
);
    logic [10:0] cnt_q;

    // ********************************************************
    // Cycle counter
    // ********************************************************
    // Loaded on the start cycle, so done rises exactly cycles later
    assign done = (cnt_q == 11'h001);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 11'h000;
        end else if (start) begin
            cnt_q <= cycles;
        end else if (abort) begin
            cnt_q <= 11'h000;
        end else if (cnt_q != 11'h000) begin
            cnt_q <= cnt_q - 11'h001;
        end
    end

endmodule : conv_timer

// file: adc_conversion_control.sv
// Summary of operation
// R01: Four-bit channel field; codes 0-7 pick inputs, 8-15 reserved.
// R02: Analog input off bit at 1 disables all analog input use.
// R03: Mode 01 is single software start; mode 10 never starts.
// R04: Software changes channel only while busy reads 0.
// R05: Software sets analog input off when no channel is used.
// R06: Start bit clears itself once conversion has begun.
// R07: Software does not restart before end flag or interrupt.
// R08: Standby resets both control registers and blocks their writes.
// R09: Software writes 0 to bit 0, 1 to bit 4 of control two.
// R10: Control two bits 7 and 6 read undefined (zero here).
// R11: Time code selects 39 to 1248 clock cycles; 001, 111 reserved.
// R12: Result bits 9-2 in high register, bits 1-0 at low bits 7-6.
// R13: End flag reads 0 before or during conversion, 1 when done. Here it stays 1 during repeat-mode conversions after the first finish.
// R14: Busy flag reads 1 during conversion, 0 when stopped.
// R15: Busy sets at start, clears at finish and on standby.
// R16: Reading the high result register clears the end flag.
// R17: Software reads the low result register before the high.
// R18: Low result register bits 3-0 read unstable (zero here).
// R19: At finish result stored, end flag set, interrupt raised together.
// R20: Mode 11 converts continuously, each finish launching the next.
// R21: Writing mode 00 stops at once; interrupted value is dropped.
// R22: Start written while busy is ignored.
// R23: Timer signals finish exactly programmed cycles after start.
`timescale 1ns/1ns
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       standby,
    input  wire logic [9:0] core_result,
    output logic            core_sample,
    output logic      [2:0] core_channel,
    output logic            analog_input_off,
    output logic            conversion_done_irq
);
    import adc_ctrl_pkg::*;

    // ********************************************************
    // Declarations
    // ********************************************************
    logic [3:0]      chan_q;
    logic            ain_off_q;
    operating_mode_e mode_q;
    logic            start_q;
    logic [5:0]      ctrl_two_q;
    conv_state_e     state_q;
    conv_state_e     state_d;
    logic [9:0]      result_q;
    logic            eoc_q;
    logic            irq_q;
    logic [7:0]      rdata_q;
    logic [10:0]     conv_len;
    logic            wr_one;
    logic            wr_two;
    logic            rd_high;
    logic            busy;
    logic            launch;
    logic            abort;
    logic            done;
    logic            capture;
    logic            relaunch;
    logic            timer_start;
    logic [10:0]     len_q;
    logic [10:0]     elapsed_q;

    // ********************************************************
    // Decode
    // ********************************************************
    // Standby blocks every control write
    assign wr_one  = reg_wr && (reg_addr == CTRL_ONE_ADDR) && !standby;
    assign wr_two  = reg_wr && (reg_addr == CTRL_TWO_ADDR) && !standby;
    assign rd_high = reg_rd && (reg_addr == RESULT_HIGH_ADDR);
    assign busy    = (state_q == ST_CONV);

    // R01: reserved channels and R02: inputs off refuse a start
    // R03: only single or repeat mode may launch
    assign launch = start_q && !standby && !busy && !chan_q[3]
                 && !ain_off_q
                 && (mode_q == MODE_SINGLE || mode_q == MODE_REPEAT);

    // R21: mode 00 write stops at once
    assign abort = busy && (standby || (wr_one
                 && reg_wdata[MODE_LSB +: 2] == MODE_OFF));

    // R19: interrupted conversions never reach the result
    assign capture  = done && !abort;
    // R20: repeat mode relaunches on every finish
    assign relaunch = capture && (mode_q == MODE_REPEAT);
    assign timer_start = launch || relaunch;

    assign core_sample      = timer_start;
    assign core_channel     = chan_q[2:0];
    assign analog_input_off = ain_off_q;
    assign conversion_done_irq = irq_q;
    assign reg_rdata        = rdata_q;

    // ********************************************************
    // Conversion time
    // ********************************************************
    // R11: code to cycles; reserved codes fall back to the longest
    always_comb begin
        case (ctrl_two_q[CONV_TIME_LSB +: 3])
            3'b000:  conv_len = CONV_CYC_39;
            3'b010:  conv_len = CONV_CYC_78;
            3'b011:  conv_len = CONV_CYC_156;
            3'b100:  conv_len = CONV_CYC_312;
            3'b101:  conv_len = CONV_CYC_624;
            3'b110:  conv_len = CONV_CYC_1248;
            default: conv_len = CONV_CYC_1248;
        endcase
    end

    // R23: conversion timer
    conv_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (timer_start),
        .abort   (abort),
        .cycles  (conv_len),
        .done    (done)
    );

    // ********************************************************
    // Control register one
    // ********************************************************
    // R08: standby holds the register at its initial value
    always_ff @(posedge clk_sys) begin
        if (rst || standby) begin
            chan_q    <= CTRL_ONE_RESET[CHAN_LSB +: 4];
            ain_off_q <= CTRL_ONE_RESET[AIN_OFF_BIT];
            mode_q    <= operating_mode_e'(CTRL_ONE_RESET[MODE_LSB +: 2]);
            start_q   <= CTRL_ONE_RESET[START_BIT];
        end else if (wr_one) begin
            chan_q    <= reg_wdata[CHAN_LSB +: 4];
            ain_off_q <= reg_wdata[AIN_OFF_BIT];
            mode_q    <= operating_mode_e'(reg_wdata[MODE_LSB +: 2]);
            // R22: start while busy is dropped
            start_q   <= reg_wdata[START_BIT] && !busy;
        end else if (start_q) begin
            // R06: clears once taken; a refused start also clears
            start_q <= 1'b0;
        end
    end

    // ********************************************************
    // Control register two
    // ********************************************************
    // R08: standby initialises and locks this one too
    always_ff @(posedge clk_sys) begin
        if (rst || standby) begin
            ctrl_two_q <= CTRL_TWO_RESET;
        end else if (wr_two) begin
            ctrl_two_q <= reg_wdata[5:0];
        end
    end

    // ********************************************************
    // Conversion state
    // ********************************************************
    // R15: busy follows start, finish and standby
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (launch) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (abort || (capture && !relaunch)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ********************************************************
    // Result and end flag
    // ********************************************************
    // R19: store result; standby discards earlier results
    always_ff @(posedge clk_sys) begin
        if (rst || standby) begin
            result_q <= RESULT_RESET;
        end else if (capture) begin
            result_q <= core_result;
        end
    end

    // R13: set on finish wins over clear by launch or R16: read
    always_ff @(posedge clk_sys) begin
        if (rst || standby) begin
            eoc_q <= 1'b0;
        end else if (capture) begin
            eoc_q <= 1'b1;
        end else if (launch || rd_high) begin
            eoc_q <= 1'b0;
        end
    end

    // R19: one-cycle interrupt pulse alongside the flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= capture;
        end
    end

    // ********************************************************
    // Read port
    // ********************************************************
    // R10, R12, R14, R18: undefined and unstable bits read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                CTRL_ONE_ADDR:
                    rdata_q <= {start_q, mode_q, ain_off_q, chan_q};
                CTRL_TWO_ADDR:
                    rdata_q <= {2'b00, ctrl_two_q};
                RESULT_HIGH_ADDR:
                    rdata_q <= result_q[9:2];
                RESULT_LOW_ADDR:
                    rdata_q <= {result_q[1:0], eoc_q, busy, 4'h0};
                default:
                    rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    // Helper: cycles elapsed since the timer was started
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            len_q     <= 11'h000;
            elapsed_q <= 11'h000;
        end else if (timer_start) begin
            len_q     <= conv_len;
            elapsed_q <= 11'h001;
        end else if (busy) begin
            elapsed_q <= elapsed_q + 11'h001;
        end
    end

    chk_start_self_clear: assert property ( // R06
        @(posedge clk_sys) disable iff (rst)
        launch |=> !start_q && busy)
        else $error("start bit did not clear on launch");

    chk_busy_ignores_start: assert property ( // R22
        @(posedge clk_sys) disable iff (rst)
        busy && wr_one && reg_wdata[START_BIT] |=> !start_q)
        else $error("start accepted while busy");

    chk_reserved_no_start: assert property ( // R03
        @(posedge clk_sys) disable iff (rst)
        !busy && start_q && (mode_q == MODE_RSVD || mode_q == MODE_OFF
                  || chan_q[3] || ain_off_q) |-> !core_sample ##1 !busy)
        else $error("launch in reserved or disabled setting");

    chk_timer_exact: assert property ( // R23
        @(posedge clk_sys) disable iff (rst)
        done && busy |-> elapsed_q == len_q)
        else $error("conversion length wrong");

    chk_capture_flags: assert property ( // R19
        @(posedge clk_sys) disable iff (rst)
        capture && !standby |=> eoc_q && irq_q
            && result_q == $past(core_result))
        else $error("finish did not store result and raise flags");

    chk_read_clears_eoc: assert property ( // R16
        @(posedge clk_sys) disable iff (rst)
        rd_high && !capture |=> !eoc_q)
        else $error("result read did not clear end flag");

    chk_abort_drops: assert property ( // R21
        @(posedge clk_sys) disable iff (rst)
        abort && !standby |=> !busy && !irq_q && $stable(result_q)
            ##1 !irq_q)
        else $error("aborted conversion was stored");

    chk_repeat_chain: assert property ( // R20
        @(posedge clk_sys) disable iff (rst)
        relaunch |=> busy && elapsed_q == 11'h001)
        else $error("repeat mode did not relaunch");

    chk_standby_resets: assert property ( // R08
        @(posedge clk_sys) disable iff (rst)
        standby |=> !busy && mode_q == MODE_OFF && ctrl_two_q == 6'h00)
        else $error("standby did not initialise control");

    chk_low_read_layout: assert property ( // R12
        @(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == RESULT_LOW_ADDR |=>
            reg_rdata == {$past(result_q[1:0]), $past(eoc_q),
                          $past(busy), 4'h0})
        else $error("low result read layout wrong");

    chk_rdata_idle_zero: assert property ( // R12
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data did not return to zero");

    chk_launch_clears_eoc: assert property ( // R13
        @(posedge clk_sys) disable iff (rst)
        launch |=> !eoc_q)
        else $error("end flag not cleared at launch");

    cov_single_done: cover property (
        @(posedge clk_sys) disable iff (rst)
        capture && mode_q == MODE_SINGLE);

    cov_repeat_chain: cover property (
        @(posedge clk_sys) disable iff (rst)
        relaunch);

    cov_abort: cover property (
        @(posedge clk_sys) disable iff (rst)
        abort && !standby);

    cov_refused_start: cover property (
        @(posedge clk_sys) disable iff (rst)
        start_q && !busy && !launch);

endmodule : adc_conversion_control

// file: core_model.sv
`timescale 1ns/1ns
module core_model (
    input  wire logic       clk_sys,
    input  wire logic       core_sample,
    input  wire logic [2:0] core_channel,
    input  wire logic       analog_input_off,
    input  wire logic [9:0] levels [8],
    output logic      [9:0] core_result
);

    // ********************************************************
    // Analog core stand-in
    // ********************************************************
    logic [2:0] chan_q = 3'h0;

    always_ff @(posedge clk_sys) begin
        if (core_sample) begin
            chan_q <= core_channel;
        end
    end

    // inputs off: output turns to garbage, never the true level
    assign core_result = analog_input_off ? ~levels[chan_q] : levels[chan_q];

endmodule : core_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import adc_ctrl_pkg::*;

    // ********************************************************
    // Signals
    // ********************************************************
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        standby   = 1'b0;
    logic [7:0]  reg_rdata;
    logic [9:0]  core_result;
    logic        core_sample;
    logic [2:0]  core_channel;
    logic        analog_input_off;
    logic        conversion_done_irq;
    logic [9:0]  levels [8];
    logic [9:0]  last;
    logic        eoc;
    logic [7:0]  exp_q [$];
    logic        rd_seen   = 1'b0;
    logic [2:0]  ch;
    logic [7:0]  bad [3]   = '{8'ha8, 8'hc2, 8'hb2};
    logic [10:0] tbl [8]   = '{CONV_CYC_39, CONV_CYC_1248, CONV_CYC_78,
                               CONV_CYC_156, CONV_CYC_312, CONV_CYC_624,
                               CONV_CYC_1248, CONV_CYC_1248};
    int          miscompares = 0;
    int          checks      = 0;
    int          seed        = 17836;
    int          irqs        = 0;
    int          samples     = 0;
    int          cyc         = 0;
    int          t0;
    int          i0;

    always #20 clk_sys = ~clk_sys;

    adc_conversion_control dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .standby(standby),
        .core_result(core_result), .core_sample(core_sample),
        .core_channel(core_channel), .analog_input_off(analog_input_off),
        .conversion_done_irq(conversion_done_irq)
    );

    core_model core_u (
        .clk_sys(clk_sys), .core_sample(core_sample),
        .core_channel(core_channel), .analog_input_off(analog_input_off),
        .levels(levels), .core_result(core_result)
    );

    // ********************************************************
    // Tasks
    // ********************************************************
    task print_verdict;
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task compare(input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : compare

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // Expectation queued first; the monitor pops it when data stands
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask : rd

    task wait_irq;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (conversion_done_irq !== 1'b1 && n < 3000);
        // A conversion that never ends is a failure in its own right
        if (conversion_done_irq !== 1'b1) begin
            miscompares++;
        end
    endtask : wait_irq

    function logic [7:0] flags(input logic busy);
        return {last[1:0], eoc, busy, 4'h0};
    endfunction : flags

    // ********************************************************
    // Monitor
    // ********************************************************
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (conversion_done_irq === 1'b1) begin
            irqs++;
        end
        if (core_sample === 1'b1) begin
            samples++;
        end
        if (rd_seen && exp_q.size() > 0) begin
            compare({4'h0, exp_q.pop_front()}, {4'h0, reg_rdata});
        end
        rd_seen <= reg_rd;
    end

    initial begin
        #(40 * 20000);
        miscompares++;
        print_verdict();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        for (int i = 0; i < 8; i++) begin
            levels[i] = 10'($random(seed));
        end
        repeat (3) @(posedge clk_sys);
        rst  <= 1'b0;
        last = 10'h000;
        eoc  = 1'b0;
        rd(CTRL_ONE_ADDR, CTRL_ONE_RESET);
        rd(CTRL_TWO_ADDR, {2'b00, CTRL_TWO_RESET});
        rd(RESULT_HIGH_ADDR, 8'h00);
        rd(RESULT_LOW_ADDR, 8'h00);
        rd(8'h33, 8'h00);
        // Bits 7:6 set, bit 0 clear and bit 4 set as software must
        wr(CTRL_TWO_ADDR, 8'hfe);
        rd(CTRL_TWO_ADDR, 8'h3e);
        // Every time code, a random channel each round
        for (int c = 0; c < 8; c++) begin
            ch = 3'($random(seed));
            wr(CTRL_TWO_ADDR, 8'(8'h10 | (c << 1)));
            wr(CTRL_ONE_ADDR, {1'b0, MODE_SINGLE, 2'b00, ch});
            rd(CTRL_ONE_ADDR, {1'b0, MODE_SINGLE, 2'b00, ch});
            compare({9'h0, ch}, {9'h0, core_channel});
            wr(CTRL_ONE_ADDR, {1'b1, MODE_SINGLE, 2'b00, ch});
            t0  = cyc;
            eoc = 1'b0;
            rd(CTRL_ONE_ADDR, {1'b0, MODE_SINGLE, 2'b00, ch});
            rd(RESULT_LOW_ADDR, flags(1'b1));
            if (c == 3) begin
                wr(CTRL_ONE_ADDR, {1'b1, MODE_SINGLE, 2'b00, ch});
            end
            wait_irq();
            compare(12'(cyc - t0), 12'(tbl[c]) + 12'd2);
            @(posedge clk_sys);
            compare(12'h0, {11'h0, conversion_done_irq});
            last = levels[ch];
            eoc  = 1'b1;
            rd(RESULT_LOW_ADDR, flags(1'b0));
            rd(RESULT_HIGH_ADDR, last[9:2]);
            eoc  = 1'b0;
            rd(RESULT_LOW_ADDR, flags(1'b0));
        end
        // Refused starts: reserved channel, reserved mode, inputs off
        i0 = samples;
        for (int k = 0; k < 3; k++) begin
            wr(CTRL_ONE_ADDR, bad[k]);
            repeat (3) @(posedge clk_sys);
            rd(CTRL_ONE_ADDR, bad[k] & 8'h7f);
            rd(RESULT_LOW_ADDR, flags(1'b0));
        end
        compare({11'h0, analog_input_off}, 12'h1);
        compare(12'(samples), 12'(i0));
        // Repeat mode, then stop in mid-conversion
        wr(CTRL_TWO_ADDR, 8'h10);
        wr(CTRL_ONE_ADDR, 8'he5);
        t0 = cyc;
        wait_irq();
        compare(12'(cyc - t0), 12'(CONV_CYC_39) + 12'd2);
        t0 = cyc;
        wait_irq();
        compare(12'(cyc - t0), 12'(CONV_CYC_39));
        last = levels[5];
        eoc  = 1'b1;
        repeat (10) @(posedge clk_sys);
        levels[5] = ~levels[5];
        wr(CTRL_ONE_ADDR, 8'h05);
        i0 = irqs;
        repeat (60) @(posedge clk_sys);
        compare(12'(irqs), 12'(i0));
        rd(RESULT_LOW_ADDR, flags(1'b0));
        rd(RESULT_HIGH_ADDR, last[9:2]);
        eoc = 1'b0;
        // Standby in mid-conversion wipes and locks the controls
        wr(CTRL_TWO_ADDR, 8'h1c);
        wr(CTRL_ONE_ADDR, 8'ha3);
        repeat (20) @(posedge clk_sys);
        standby <= 1'b1;
        i0 = irqs;
        repeat (2) @(posedge clk_sys);
        rd(CTRL_ONE_ADDR, 8'h00);
        rd(CTRL_TWO_ADDR, 8'h00);
        wr(CTRL_ONE_ADDR, 8'h23);
        rd(CTRL_ONE_ADDR, 8'h00);
        last = 10'h000;
        rd(RESULT_LOW_ADDR, flags(1'b0));
        rd(RESULT_HIGH_ADDR, 8'h00);
        standby <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd(CTRL_ONE_ADDR, 8'h00);
        compare(12'(irqs), 12'(i0));
        // No channel in use any more, so the inputs are switched off
        wr(CTRL_ONE_ADDR, 8'h10);
        rd(CTRL_ONE_ADDR, 8'h10);
        repeat (3) @(posedge clk_sys);
        print_verdict();
    end

endmodule : tb_top
